// ==== pkg/ebra_pkg.sv ====
// constants and types for the external bus release arbiter
package ebra_pkg;

  // port 1 control register location and its release-enable field
  localparam logic [15:0] PORT1_CR_ADDR = 16'hfffc;
  localparam int BUS_RELEASE_ENABLE_BIT = 3;
  localparam logic [7:0] PORT1_CR_RESET = 8'h00;

  // on-chip register field, accessed a byte at a time
  localparam logic [15:0] REG_FIELD_LO = 16'hff80;
  localparam logic [15:0] REG_FIELD_HI = 16'hffff;

  // high samples of the request needed to leave the released state
  localparam logic [1:0] EXIT_HIGH_SAMPLES = 2'h2;

  // synchroniser idle levels: request high, init high, standby low
  localparam logic [2:0] PIN_SYNC_RESET = 3'h3;

  // arbiter states, one-hot
  typedef enum logic [4:0] {
    EBRA_RUN = 5'h01, // processor owns the bus
    EBRA_PEND = 5'h02, // request latched, waiting for cycle end
    EBRA_FLOAT = 5'h04, // bus pins floated, acknowledge not yet low
    EBRA_GRANT = 5'h08, // acknowledge low, outside master owns the bus
    EBRA_RESUME = 5'h10 // acknowledge high again, taking the bus back
  } ebra_state_e;

endpackage

// ==== logic/ebra_sync.sv ====
// two flip-flop synchroniser for pins arriving from outside the clock
`timescale 1ns/1ps
module ebra_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  // each bit passes two flops; the first is read by the second only
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic settled;
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta <= RESET_VAL[i];
          settled <= RESET_VAL[i];
        end else begin
          meta <= pin_in[i];
          settled <= meta;
        end
      end
      // one process per flop pair; the vector is only collected here
      assign pin_sync[i] = settled;
    end
  endgenerate

endmodule // ebra_sync

// ==== logic/ebra_arbiter.sv ====
// external bus release arbiter: request/acknowledge pins and bus hand-over
// Operation
// - sample request in every memory cycle; release at that cycle's end
// - word access external or register field: finish both bytes first
// - during multiply/divide also sample at internal cycles and release
// - bus can be granted in sleep mode as well as while running
// - no interrupt accepted while the bus is granted
// - in an access with a wait state, sample at wait state start
// - request seen in external access: acknowledge low after cycle ends
// - released: sample each state, exit after two high samples in a row
// - after the high samples acknowledge goes high, then bus resumed
// - release only when enable bit is 1; else pins are port pins
// - enable bit is bit 3 of the port 1 control register
// - while enable is clear, low request levels are not latched
// - init pin low resets everything unless in hardware standby
// - on grant, float address, data and control, then acknowledge low
`timescale 1ns/1ps
module ebra_arbiter (
  input wire logic core_clk,
  input wire logic rst,
  // pins from outside the clock domain
  input wire logic bus_request_n,
  input wire logic chip_init_n,
  input wire logic hw_standby,
  // processor bus cycle status, same clock
  input wire logic access_start,
  input wire logic access_end,
  input wire logic access_external,
  input wire logic access_word,
  input wire logic access_first_byte,
  input wire logic [15:0] access_addr,
  input wire logic wait_state,
  input wire logic mul_div_active,
  input wire logic internal_cycle_end,
  input wire logic sleep_mode,
  // processor register write/read port for the port 1 control register
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] port1_control_register,
  // general-purpose port use of the two pins
  input wire logic port1_bit_out,
  input wire logic port1_dir_out,
  output logic port1_bit_in,
  // acknowledge pin: value and enable, enable low while driving
  output logic bus_ack_n,
  output logic bus_ack_oe_n,
  // to the processor and bus pin drivers
  output logic bus_float,
  output logic cpu_halt,
  output logic irq_block,
  output logic chip_reset
);

  logic [2:0] pin_sync;
  logic req_low;
  logic init_low;
  logic standby;
  logic init_reset;
  logic bus_release_enable;
  ebra_pkg::ebra_state_e state;
  ebra_pkg::ebra_state_e next_state;
  logic [1:0] high_count;
  logic [1:0] next_high_count;
  logic wait_state_d;
  logic wait_start;
  logic in_reg_field;
  logic hold_pair;
  logic in_access;
  logic sample_point;
  logic release_point;

  // request, init and standby pins are synchronised before any use
  ebra_sync #(
    .WIDTH(3),
    .RESET_VAL(ebra_pkg::PIN_SYNC_RESET)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in({hw_standby, chip_init_n, bus_request_n}),
    .pin_sync(pin_sync)
  );

  assign req_low = ~pin_sync[0];
  assign init_low = ~pin_sync[1];
  assign standby = pin_sync[2];

  // init pin low resets the block, ignored in hardware standby
  assign init_reset = rst | (init_low & ~standby);

  // reset state indication for the rest of the chip
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chip_reset <= 1'b1;
    end else begin
      chip_reset <= init_low & ~standby;
    end
  end

  // port 1 control register, written by the processor at its address
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      port1_control_register <= ebra_pkg::PORT1_CR_RESET;
    end else if (reg_wr && reg_addr == ebra_pkg::PORT1_CR_ADDR) begin
      port1_control_register <= reg_wdata;
    end
  end

  assign bus_release_enable =
    port1_control_register[ebra_pkg::BUS_RELEASE_ENABLE_BIT];

  // wait state edge for sampling at its start
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      wait_state_d <= 1'b0;
    end else begin
      wait_state_d <= wait_state;
    end
  end

  assign wait_start = wait_state & ~wait_state_d;

  // in-access flag: between access start and end
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      in_access <= 1'b0;
    end else if (access_start) begin
      in_access <= 1'b1;
    end else if (access_end) begin
      in_access <= 1'b0;
    end
  end

  // word access that is split into two byte cycles
  assign in_reg_field = access_addr >= ebra_pkg::REG_FIELD_LO &&
    access_addr <= ebra_pkg::REG_FIELD_HI;
  assign hold_pair = access_word & access_first_byte &
    (access_external | in_reg_field);

  // points where the request is looked at
  always_comb begin
    sample_point = 1'b0;
    if (access_start) begin
      sample_point = 1'b1;
    end
    if (wait_start) begin
      sample_point = 1'b1;
    end
    if (mul_div_active && internal_cycle_end) begin
      sample_point = 1'b1;
    end
    if (sleep_mode) begin
      sample_point = 1'b1;
    end
  end

  // points where the bus may be handed over
  always_comb begin
    release_point = 1'b0;
    if (access_end && !hold_pair) begin
      release_point = 1'b1;
    end
    if (!in_access && mul_div_active && internal_cycle_end) begin
      release_point = 1'b1;
    end
    if (!in_access && sleep_mode) begin
      release_point = 1'b1;
    end
  end

  // next state of the hand-over sequence
  always_comb begin
    next_state = state;
    next_high_count = high_count;
    case (state)
      ebra_pkg::EBRA_RUN: begin
        next_high_count = 2'h0;
        // low requests are latched only while release is enabled
        if (bus_release_enable && req_low && sample_point) begin
          if (release_point) begin
            next_state = ebra_pkg::EBRA_FLOAT;
          end else begin
            next_state = ebra_pkg::EBRA_PEND;
          end
        end
      end
      ebra_pkg::EBRA_PEND: begin
        // request held low by the master until acknowledge
        if (!bus_release_enable) begin
          next_state = ebra_pkg::EBRA_RUN;
        end else if (release_point) begin
          next_state = ebra_pkg::EBRA_FLOAT;
        end
      end
      ebra_pkg::EBRA_FLOAT: begin
        next_high_count = 2'h0;
        next_state = ebra_pkg::EBRA_GRANT;
      end
      ebra_pkg::EBRA_GRANT: begin
        // every state: count consecutive high samples
        if (req_low) begin
          next_high_count = 2'h0;
        end else if (high_count + 2'h1 >= ebra_pkg::EXIT_HIGH_SAMPLES) begin
          next_high_count = 2'h0;
          next_state = ebra_pkg::EBRA_RESUME;
        end else begin
          next_high_count = high_count + 2'h1;
        end
      end
      ebra_pkg::EBRA_RESUME: begin
        next_state = ebra_pkg::EBRA_RUN;
      end
      default: begin
        next_state = ebra_pkg::EBRA_RUN;
        next_high_count = 2'h0;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      state <= ebra_pkg::EBRA_RUN;
      high_count <= 2'h0;
    end else begin
      state <= next_state;
      high_count <= next_high_count;
    end
  end

  // bus pins float from the float state until the bus is resumed
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      bus_float <= 1'b0;
    end else begin
      bus_float <= next_state == ebra_pkg::EBRA_FLOAT ||
        next_state == ebra_pkg::EBRA_GRANT;
    end
  end

  // processor halts from float through resume, one cycle past the acknowledge going high
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      cpu_halt <= 1'b0;
    end else begin
      cpu_halt <= next_state == ebra_pkg::EBRA_FLOAT ||
        next_state == ebra_pkg::EBRA_GRANT ||
        next_state == ebra_pkg::EBRA_RESUME;
    end
  end

  // interrupts are not recognised while the bus is handed over
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      irq_block <= 1'b0;
    end else begin
      irq_block <= next_state == ebra_pkg::EBRA_FLOAT ||
        next_state == ebra_pkg::EBRA_GRANT;
    end
  end

  // acknowledge pin: release function or general-purpose output
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      bus_ack_n <= 1'b1;
      bus_ack_oe_n <= 1'b1;
    end else if (next_state == ebra_pkg::EBRA_GRANT) begin
      bus_ack_n <= 1'b0;
      bus_ack_oe_n <= 1'b0;
    end else if (port1_control_register
        [ebra_pkg::BUS_RELEASE_ENABLE_BIT] ||
        (reg_wr && reg_addr == ebra_pkg::PORT1_CR_ADDR &&
        reg_wdata[ebra_pkg::BUS_RELEASE_ENABLE_BIT])) begin
      bus_ack_n <= 1'b1;
      bus_ack_oe_n <= 1'b0;
    end else begin
      bus_ack_n <= port1_bit_out;
      bus_ack_oe_n <= ~port1_dir_out;
    end
  end

  // request pin read back as a port input
  always_ff @(posedge core_clk) begin
    if (init_reset) begin
      port1_bit_in <= 1'b1;
    end else begin
      port1_bit_in <= pin_sync[0];
    end
  end

endmodule // ebra_arbiter

// ==== bench/ebra_master_model.sv ====
// outside bus master model driving the request pin
`timescale 1ns/1ps
module ebra_master_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic want,
  input wire logic bus_float,
  input wire logic bus_ack_n,
  output logic bus_request_n
);
  logic held;
  // once the device commits, keep asking until ack goes low
  always_ff @(posedge core_clk) begin
    if (rst || !bus_ack_n) begin
      held <= 1'h0;
    end else if (bus_float) begin
      held <= 1'h1;
    end
  end
  // a driven level; while granted the model owns the bus lines
  assign bus_request_n = !(want || held || (bus_float && bus_ack_n));
endmodule // ebra_master_model

// ==== bench/ebra_arbiter_properties.sv ====
// concurrent checks on the bus release arbiter ports
`timescale 1ns/1ps
module ebra_arbiter_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bus_request_n,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] port1_control_register,
  input wire logic bus_ack_n,
  input wire logic bus_ack_oe_n,
  input wire logic bus_float,
  input wire logic cpu_halt,
  input wire logic irq_block
);
  wire logic en;
  wire logic gnt;
  // ack is only meaningful as a grant while release is enabled
  assign en = port1_control_register[ebra_pkg::BUS_RELEASE_ENABLE_BIT];
  assign gnt = en && !bus_ack_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_fl; $rose(bus_float) |=> gnt; endproperty
  a_fl: assert property (p_fl) else $error("no ack");
  property p_ir; gnt |-> irq_block && bus_float; endproperty
  a_ir: assert property (p_ir) else $error("irq open");
  property p_en; $rose(bus_float) |-> $past(en); endproperty
  a_en: assert property (p_en) else $error("not enabled");
  property p_ex; (gnt && bus_request_n) [*4] |=> bus_ack_n; endproperty
  a_ex: assert property (p_ex) else $error("no exit");
  property p_st; (gnt && !bus_request_n) [*3] |=> !bus_ack_n; endproperty
  a_st: assert property (p_st) else $error("early exit");
  property p_hl;
    $rose(bus_ack_n) && cpu_halt |-> !bus_float && !irq_block ##1 !cpu_halt;
  endproperty
  a_hl: assert property (p_hl) else $error("bad resume");
  property p_hi; en && !cpu_halt |-> bus_ack_n && !bus_ack_oe_n; endproperty
  a_hi: assert property (p_hi) else $error("ack not high");
  property p_cf;
    reg_wr && reg_addr == ebra_pkg::PORT1_CR_ADDR |=> en == $past(reg_wdata[3]);
  endproperty
  a_cf: assert property (p_cf) else $error("enable lost");
  c_gr: cover property ($fell(bus_ack_n) && en);
  c_rs: cover property ($rose(bus_ack_n) && cpu_halt);
  c_cf: cover property (reg_wr && reg_addr == ebra_pkg::PORT1_CR_ADDR);
endmodule // ebra_arbiter_checker
bind ebra_arbiter ebra_arbiter_checker chk_u (
  .core_clk, .rst, .bus_request_n, .reg_wr, .reg_addr, .reg_wdata,
  .port1_control_register, .bus_ack_n, .bus_ack_oe_n, .bus_float,
  .cpu_halt, .irq_block
);

// ==== bench/test_external_bus_release_arbiter.sv ====
// testbench for the external bus release arbiter
`timescale 1ns/1ps
module test_external_bus_release_arbiter;
  logic core_clk = 1'h0, rst = 1'h1, want = 1'h0;
  logic access_start = 1'h0, access_end = 1'h0, access_external = 1'h0;
  logic access_word = 1'h0, access_first_byte = 1'h0, wait_state = 1'h0;
  logic mul_div_active = 1'h0, internal_cycle_end = 1'h0, sleep_mode = 1'h0;
  logic reg_wr = 1'h0, chip_init_n = 1'h1, hw_standby = 1'h0;
  logic port1_bit_out = 1'h1, port1_dir_out = 1'h0;
  logic [15:0] reg_addr = 16'h0000, access_addr = 16'h1000;
  logic [7:0] reg_wdata = 8'h00, port1_control_register;
  logic bus_request_n, port1_bit_in, bus_ack_n, bus_ack_oe_n;
  logic bus_float, cpu_halt, irq_block, chip_reset;
  int bad_count = 0, n_checks = 0;
  // design and far-side master
  ebra_arbiter dut_u (
    .core_clk, .rst, .bus_request_n, .chip_init_n, .hw_standby,
    .access_start, .access_end, .access_external, .access_word,
    .access_first_byte, .access_addr, .wait_state, .mul_div_active,
    .internal_cycle_end, .sleep_mode, .reg_wr, .reg_addr, .reg_wdata,
    .port1_control_register, .port1_bit_out, .port1_dir_out,
    .port1_bit_in, .bus_ack_n, .bus_ack_oe_n, .bus_float, .cpu_halt,
    .irq_block, .chip_reset
  );
  ebra_master_model master_u (
    .core_clk, .rst, .want, .bus_float, .bus_ack_n, .bus_request_n
  );
  always #5 core_clk = ~core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_ack(input logic lvl);
    int i;
    for (i = 0; i < 20 && bus_ack_n !== lvl; i++) begin
      tick(1);
    end
    if (i == 20) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, bus_ack_n, lvl);
      final_report();
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    tick(1);
    reg_wr = 1'h0;
    tick(1);
  endtask
  // grant, a one-sample glitch on exit, then hand the bus back
  task automatic hand_back;
    chk(8'(bus_float), 8'h01);
    chk(8'(cpu_halt), 8'h01);
    wait_ack(1'h0);
    chk(8'(irq_block), 8'h01);
    want = 1'h0;
    tick(2);
    want = 1'h1;
    tick(4);
    chk(8'(bus_ack_n), 8'h00);
    want = 1'h0;
    wait_ack(1'h1);
    chk(8'(bus_float), 8'h00);
    chk(8'(irq_block), 8'h00);
    tick(1);
    chk(8'(cpu_halt), 8'h00);
  endtask
  task automatic t_disabled;
    chk(port1_control_register, 8'h00);
    // disabled: the acknowledge pin is a plain port output
    chk(8'(bus_ack_oe_n), 8'h01);
    port1_dir_out = 1'h1;
    port1_bit_out = 1'h0;
    tick(1);
    chk(8'(bus_ack_n), 8'h00);
    chk(8'(bus_ack_oe_n), 8'h00);
    port1_bit_out = 1'h1;
    port1_dir_out = 1'h0;
    want = 1'h1;
    tick(3);
    pulse(access_start);
    pulse(access_end);
    chk(8'(bus_float), 8'h00);
    chk(8'(port1_bit_in), 8'h00);
    want = 1'h0;
    tick(3);
    wreg(ebra_pkg::PORT1_CR_ADDR, 8'h08);
    chk(port1_control_register, 8'h08);
    chk(8'(bus_ack_n), 8'h01);
    chk(8'(bus_ack_oe_n), 8'h00);
    wreg(16'hfffd, 8'h00);
    chk(port1_control_register, 8'h08);
    // pending request dropped when enable is cleared before cycle end
    want = 1'h1;
    tick(3);
    pulse(access_start);
    wreg(ebra_pkg::PORT1_CR_ADDR, 8'h00);
    pulse(access_end);
    chk(8'(bus_float), 8'h00);
    want = 1'h0;
    wreg(ebra_pkg::PORT1_CR_ADDR, 8'h08);
    $display("test enable done");
  endtask
  task automatic t_word;
    for (int k = 0; k < 2; k++) begin
      // external word first, then an internal word in the register field
      access_external = k == 0;
      access_addr = k == 0 ? 16'h1000 : 16'hff90;
      access_word = 1'h1;
      access_first_byte = 1'h1;
      want = 1'h1;
      tick(3);
      pulse(access_start);
      pulse(access_end);
      chk(8'(bus_float), 8'h00);
      access_first_byte = 1'h0;
      pulse(access_start);
      pulse(access_end);
      hand_back();
    end
    access_word = 1'h0;
    access_addr = 16'h1000;
    $display("test word done");
  endtask
  task automatic t_wait;
    pulse(access_start);
    want = 1'h1;
    tick(3);
    pulse(wait_state);
    pulse(access_end);
    hand_back();
    $display("test wait done");
  endtask
  task automatic t_other;
    mul_div_active = 1'h1;
    want = 1'h1;
    tick(3);
    pulse(internal_cycle_end);
    hand_back();
    mul_div_active = 1'h0;
    sleep_mode = 1'h1;
    want = 1'h1;
    tick(3);
    hand_back();
    sleep_mode = 1'h0;
    chip_init_n = 1'h0;
    tick(4);
    chk(8'(chip_reset), 8'h01);
    chk(port1_control_register, 8'h00);
    chip_init_n = 1'h1;
    tick(4);
    chk(8'(chip_reset), 8'h00);
    $display("test other done");
  endtask
  initial begin
    tick(8);
    rst = 1'h0;
    tick(1);
    t_disabled();
    t_word();
    t_wait();
    t_other();
    final_report();
  end
endmodule // test_external_bus_release_arbiter
